// *** pee_pkg.sv ***
package pee_pkg;

  // Clock figures
  localparam int CLK_PERIOD_NS = 8;

  // Pin timing, in nanoseconds as printed
  localparam int READ_ACCESS_NS   = 150;
  localparam int FLOAT_NS         = 50;
  localparam int WRITE_PULSE_NS   = 100;
  localparam int WRITE_HIGH_NS    = 50;
  localparam int ADDR_HOLD_NS     = 50;
  localparam int TOGGLE_OE_HIGH_NS = 150;

  // Cycle counts; least times round up
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int FLOAT_CYC =
    (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC =
    (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC =
    (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_HIGH_CYC =
    (TOGGLE_OE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Long times in microseconds; longest times round down
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int PROGRAM_CYCLE_US    = 10000;
  localparam int PROGRAM_FAST_US     = 2000;
  localparam int BYTE_LOAD_WINDOW_CYC =
    BYTE_LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_US * 1000 / CLK_PERIOD_NS;
  localparam int PROGRAM_FAST_CYC  = PROGRAM_FAST_US * 1000 / CLK_PERIOD_NS;

  // Widths and fields
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int PAGE_LSB    = 6;
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int CNT_W       = 24;

  // Reset values of pin drivers
  localparam logic       PIN_IDLE  = 1'b1;
  localparam logic [7:0] DATA_RST  = 8'h00;

  typedef enum logic [2:0] {
    PEE_IDLE  = 3'b000,
    PEE_SETUP = 3'b001,
    PEE_PULSE = 3'b011,
    PEE_HOLD  = 3'b010,
    PEE_READ  = 3'b110,
    PEE_GAP   = 3'b111,
    PEE_ERASE = 3'b101
  } pee_state_t;

endpackage : pee_pkg

// *** pee_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Write: select low, gate high, strobe low
// - Chip erase: high-voltage gate, strobe low
// - Next page byte within 150 us; a write taken as a read spanning window expiry ends can come later
// - Page address bits equal at each strobe
// - Gate high while strobe and select low
module pee_host
  import pee_pkg::*;
#(
  parameter int unsigned BLW_CYC  = BYTE_LOAD_WINDOW_CYC,
  parameter int unsigned PROG_CYC = PROGRAM_CYCLE_CYC
) (
  // Clock and reset
  input  wire  logic              clock,
  input  wire  logic              reset_n,
  // User command port
  input  wire  logic              cmd_valid,
  output logic                    cmd_ready,
  input  wire  logic              cmd_write,
  input  wire  logic              cmd_erase,
  input  wire  logic              cmd_last,
  input  wire  logic [ADDR_W-1:0] cmd_addr,
  input  wire  logic [DATA_W-1:0] cmd_wdata,
  output logic                    rd_valid,
  output logic [DATA_W-1:0]       rd_data,
  output logic                    busy,
  output logic                    page_error,
  // Device pins
  output logic                    chip_sel_n,
  output logic                    out_gate_n,
  output logic                    wr_strobe_n,
  output logic                    erase_hv_en,
  output logic [ADDR_W-1:0]       addr,
  output logic [DATA_W-1:0]       data_o,
  output logic                    data_oe_n,
  input  wire  logic [DATA_W-1:0] data_i
);

  pee_state_t              state_r;
  logic [CNT_W-1:0]        tmr_r;
  logic [CNT_W-1:0]        win_r;
  logic                    in_page_r;
  logic [ADDR_W-1:0]       page_r;
  logic                    is_er_r;
  logic                    got_one_r;
  logic [CNT_W-1:0]        prog_r;
  logic                    tmr_watch_done;
  logic                    last_r;
  logic                    poll_r;
  logic [ADDR_W-1:0]       last_addr_r;
  logic [DATA_W-1:0]       last_data_r;
  logic [DATA_W-1:0]       prev_rd_r;
  logic                    have_prev_r;
  logic [DATA_W-1:0]       s1_r;
  logic [DATA_W-1:0]       s2_r;
  logic [DATA_W-1:0]       s3_r;
  logic                    take;
  logic                    tmr_done;

  function automatic logic same_page(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    same_page = a[ADDR_W-1:PAGE_LSB] == b[ADDR_W-1:PAGE_LSB];
  endfunction : same_page

  // Commands only taken idle; a new page address waits for the window
  assign take      = cmd_valid && cmd_ready;
  assign tmr_done  = tmr_r == '0;
  assign cmd_ready = (state_r == PEE_IDLE) && !poll_r &&
                     !(in_page_r && cmd_write && !cmd_erase &&
                       !same_page(cmd_addr, page_r));
  assign busy      = poll_r || in_page_r || state_r != PEE_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser; only the last two stages are compared
  always_ff @(posedge clock) begin
    s1_r <= data_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer with pin strobes
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r     <= PEE_IDLE;
      tmr_r       <= '0;
      chip_sel_n  <= PIN_IDLE;
      out_gate_n  <= PIN_IDLE;
      wr_strobe_n <= PIN_IDLE;
      erase_hv_en <= 1'b0;
      data_oe_n   <= PIN_IDLE;
      addr        <= '0;
      data_o      <= DATA_RST;
      is_er_r     <= 1'b0;
      last_r      <= 1'b0;
    end else begin
      if (!tmr_done) tmr_r <= tmr_r - 1'b1;
      case (state_r)
        PEE_IDLE: begin
          if (take) begin
            addr    <= cmd_addr;
            data_o  <= cmd_wdata;
            is_er_r <= cmd_erase;
            last_r  <= cmd_last;
            chip_sel_n <= 1'b0;
            if (cmd_write || cmd_erase) begin
              out_gate_n <= 1'b1;
              data_oe_n  <= 1'b0;
              erase_hv_en <= cmd_erase;
              state_r    <= PEE_SETUP;
            end else begin
              out_gate_n <= 1'b0;
              tmr_r   <= CNT_W'(READ_ACCESS_CYC);
              state_r <= PEE_READ;
            end
          end else if (poll_r) begin
            // Status read of the last byte while programming runs
            addr       <= last_addr_r;
            chip_sel_n <= 1'b0;
            out_gate_n <= 1'b0;
            tmr_r      <= CNT_W'(READ_ACCESS_CYC);
            state_r    <= PEE_READ;
          end
        end
        PEE_SETUP: begin
          // Address settles before the falling strobe edge
          wr_strobe_n <= 1'b0;
          tmr_r   <= CNT_W'(WRITE_PULSE_CYC);
          state_r <= is_er_r ? PEE_ERASE : PEE_PULSE;
        end
        PEE_PULSE, PEE_ERASE: begin
          if (tmr_done) begin
            // Data taken by the device on this rising edge
            wr_strobe_n <= 1'b1;
            tmr_r   <= CNT_W'(ADDR_HOLD_CYC);
            state_r <= PEE_HOLD;
          end
        end
        PEE_HOLD: begin
          // Gate stays high until strobe is back up
          if (tmr_done) begin
            chip_sel_n  <= 1'b1;
            data_oe_n   <= 1'b1;
            erase_hv_en <= 1'b0;
            tmr_r   <= CNT_W'(WRITE_HIGH_CYC);
            state_r <= PEE_GAP;
          end
        end
        PEE_READ: begin
          if (tmr_done) begin
            out_gate_n <= 1'b1;
            chip_sel_n <= 1'b1;
            // Gate high pulse long enough for toggle reads
            tmr_r   <= CNT_W'(OE_HIGH_CYC);
            state_r <= PEE_GAP;
          end
        end
        PEE_GAP: begin
          if (tmr_done) state_r <= PEE_IDLE;
        end
        default: state_r <= PEE_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte load window; expiry or last byte ends the page
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      in_page_r <= 1'b0;
      win_r     <= '0;
      page_r    <= '0;
      poll_r    <= 1'b0;
      page_error <= 1'b0;
    end else begin
      page_error <= in_page_r && cmd_valid && cmd_write && !cmd_erase &&
                    !same_page(cmd_addr, page_r) && state_r == PEE_IDLE;
      if (take && cmd_write && !cmd_erase) begin
        in_page_r <= 1'b1;
        page_r    <= cmd_addr;
        win_r     <= CNT_W'(BLW_CYC);
      end else if (in_page_r) begin
        // Window runs in every state; page closes only in idle, so a write after a read spanning expiry can pass the device limit
        if (win_r != '0) win_r <= win_r - 1'b1;
        if (state_r == PEE_IDLE && (win_r == '0 || last_r)) begin
          in_page_r <= 1'b0;
          poll_r    <= 1'b1;
        end
      end
      if (take && cmd_erase) poll_r <= 1'b1;
      // Poll until status settles or the device limit passes
      if (poll_r && rd_valid && prev_rd_r == rd_data &&
          have_prev_r && rd_data == last_data_r)
        poll_r <= 1'b0;
      if (poll_r && tmr_watch_done) poll_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming watchdog; bounded by the worst-case cycle time
  assign tmr_watch_done = prog_r == '0;
  always_ff @(posedge clock) begin
    if (!reset_n) prog_r <= '0;
    else if (!poll_r) prog_r <= CNT_W'(PROG_CYC);
    else if (!tmr_watch_done) prog_r <= prog_r - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read capture and status tracking
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_valid    <= 1'b0;
      rd_data     <= DATA_RST;
      prev_rd_r   <= DATA_RST;
      have_prev_r <= 1'b0;
      got_one_r   <= 1'b0;
      last_addr_r <= '0;
      last_data_r <= DATA_RST;
    end else begin
      rd_valid <= 1'b0;
      if (take && cmd_write && !cmd_erase) begin
        last_addr_r <= cmd_addr;
        last_data_r <= cmd_wdata;
        have_prev_r <= 1'b0;
        got_one_r   <= 1'b0;
      end
      if (state_r == PEE_READ && tmr_done && s2_r == s3_r) begin
        rd_valid  <= 1'b1;
        rd_data   <= s3_r;
        prev_rd_r <= rd_data;
        // First read after a write only arms; two must agree
        have_prev_r <= got_one_r;
        got_one_r   <= 1'b1;
      end
      // Inverted polling bit marks unfinished programming
      if (rd_valid && poll_r && addr == last_addr_r &&
          rd_data[POLL_BIT] != last_data_r[POLL_BIT]) begin
        have_prev_r <= 1'b0;
        got_one_r   <= 1'b0;
      end
    end
  end

endmodule : pee_host
`default_nettype wire

// *** pee_host_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module pee_host_chk
  import pee_pkg::*;
#(
  parameter int unsigned BLW_CYC  = 50,
  parameter int unsigned PROG_CYC = 200
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              reset_n,
  // Device pins
  input wire logic              chip_sel_n,
  input wire logic              out_gate_n,
  input wire logic              wr_strobe_n,
  input wire logic              erase_hv_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              data_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] low_r;
  logic [6:0] page_r;
  int         win_r;
  // Strobe low time, to judge the pulse width
  always_ff @(posedge clock)
    low_r <= (!reset_n || wr_strobe_n) ? 8'h00 : low_r + 8'h01;
  // Page of the open load; expires like the device window
  always_ff @(posedge clock) begin
    if (!reset_n) win_r <= 0;
    else if ($fell(wr_strobe_n) && !erase_hv_en) begin
      win_r  <= BLW_CYC;
      page_r <= addr[ADDR_W-1:PAGE_LSB];
    end else if (win_r > 0) win_r <= win_r - 1;
  end
  chk_gate_high: assert property (!wr_strobe_n && !chip_sel_n
    && !erase_hv_en |-> out_gate_n) else $error("gate low in write");
  chk_no_clash: assert property (!data_oe_n |-> out_gate_n)
    else $error("host drives while gate low");
  chk_read_mode: assert property (!chip_sel_n && !out_gate_n
    |-> data_oe_n && wr_strobe_n) else $error("bad read mode");
  chk_erase_sel: assert property (erase_hv_en && !wr_strobe_n
    |-> !chip_sel_n) else $error("erase without select");
  chk_page_same: assert property ($fell(wr_strobe_n) && win_r != 0
    && !erase_hv_en |-> addr[ADDR_W-1:PAGE_LSB] == page_r)
    else $error("page changed in load");
  chk_pulse_wide: assert property ($rose(wr_strobe_n)
    |-> low_r >= WRITE_PULSE_CYC) else $error("strobe pulse short");
  chk_addr_hold: assert property (!wr_strobe_n && !$past(wr_strobe_n)
    |-> $stable(addr)) else $error("address moved in pulse");
  chk_data_setup: assert property ($rose(wr_strobe_n) && !chip_sel_n
    && !$past(erase_hv_en) |-> !$past(data_oe_n) && $stable(data_o))
    else $error("data not held at strobe rise");
endmodule : pee_host_chk
bind pee_host pee_host_chk #(.BLW_CYC(BLW_CYC), .PROG_CYC(PROG_CYC))
  i_pee_host_chk (.clock, .reset_n, .chip_sel_n, .out_gate_n,
  .wr_strobe_n, .erase_hv_en, .addr, .data_o, .data_oe_n);
`default_nettype wire

// *** pee_dev_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pee_dev_model
  import pee_pkg::*;
#(
  parameter int BLW  = 50,
  parameter int PROG = 120
) (
  // Clock, to time the window and self-timed cycle and to update erase and the data output
  input  wire logic              clock,
  // Device pins
  input  wire logic              chip_sel_n,
  input  wire logic              out_gate_n,
  input  wire logic              wr_strobe_n,
  input  wire logic              erase_hv_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_o,
  output logic      [DATA_W-1:0] data_i
);
  logic [7:0]        mem [0:8191];
  logic [ADDR_W-1:0] lat_a, last_a;
  logic              act = 1'b0, tog = 1'b0, rd, bsy;
  int                win = 0, prog = 0;
  assign rd  = !chip_sel_n && !out_gate_n && wr_strobe_n;
  assign bsy = (win > 0) || (prog > 0);
  // Known pattern so reads of untouched bytes can be predicted
  initial begin
    data_i = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'hA5;
  end
  // Address on the later falling edge; inhibit unless a write mode
  always @(negedge wr_strobe_n or negedge chip_sel_n)
    if (!chip_sel_n && !wr_strobe_n && out_gate_n && !erase_hv_en) begin
      lat_a = addr;
      act   = 1'b1;
    end
  // Data on the first rising edge; only the addressed byte changes
  always @(posedge wr_strobe_n or posedge chip_sel_n)
    if (act) begin
      act         = 1'b0;
      mem[lat_a]  = data_o;
      last_a      = lat_a;
      win         = BLW;
    end
  // Each select or gate fall while the window is open or programming runs flips the status bit
  always @(negedge out_gate_n or negedge chip_sel_n)
    if (bsy) tog = ~tog;
  // Window expiry starts programming; released bus shows moving junk
  always @(posedge clock) begin
    if (win > 0) begin
      win = win - 1;
      if (win == 0) prog = PROG;
    end else if (prog > 0) prog = prog - 1;
    if (!chip_sel_n && !wr_strobe_n && erase_hv_en)
      for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
    if (!rd) data_i <= ~data_i;
    else if (!bsy) data_i <= mem[addr];
    else data_i <= {mem[addr][7] ^ (addr == last_a), tog,
                    mem[addr][5:0]};
  end
endmodule : pee_dev_model
`default_nettype wire

// *** pee_host_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module pee_host_test
  import pee_pkg::*;
;
  logic              clock, reset_n, cmd_valid, cmd_write, cmd_erase;
  logic              cmd_last, cmd_ready, rd_valid, busy, page_error;
  logic              chip_sel_n, out_gate_n, wr_strobe_n, erase_hv_en;
  logic              data_oe_n, perr;
  logic [ADDR_W-1:0] cmd_addr, addr;
  logic [DATA_W-1:0] cmd_wdata, rd_data, data_o, data_i;
  int                err_count = 0, total_checks = 0;
  pee_host #(.BLW_CYC(50), .PROG_CYC(400)) i_pee_host (.clock, .reset_n,
    .cmd_valid, .cmd_ready, .cmd_write, .cmd_erase, .cmd_last, .cmd_addr,
    .cmd_wdata, .rd_valid, .rd_data, .busy, .page_error, .chip_sel_n,
    .out_gate_n, .wr_strobe_n, .erase_hv_en, .addr, .data_o, .data_oe_n,
    .data_i);
  pee_dev_model #(.BLW(50), .PROG(120)) i_pee_dev_model (.clock,
    .chip_sel_n, .out_gate_n, .wr_strobe_n, .erase_hv_en, .addr, .data_o,
    .data_i);
  function automatic logic [7:0] pat(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : pat
  task automatic summarize;
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Hold a command until taken; notes any refusal pulse meanwhile
  task automatic cmd(input logic w, e, l, input logic [12:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    {cmd_valid, cmd_write, cmd_erase, cmd_last} <= {1'b1, w, e, l};
    cmd_addr  <= a;
    cmd_wdata <= d;
    do begin
      @(negedge clock);
      if (page_error === 1'b1) perr = 1'b1;
      n++;
    end while (cmd_ready !== 1'b1 && n < 3000);
    `CHK(cmd_ready, 1'b1)
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    int n;
    n = 0;
    cmd(1'b0, 1'b0, 1'b0, a, 8'h00);
    do begin @(negedge clock); n++; end while (rd_valid !== 1'b1 && n < 99);
    `CHK({rd_valid, rd_data}, {1'b1, e})
  endtask : rd
  task automatic idle;
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (busy !== 1'b0 && n < 3000);
    `CHK(busy, 1'b0)
  endtask : idle
  ////////////////////////////////////////////////////////////////////////
  // One byte with an early page end; busy until polling matches
  task automatic t_byte;
    int n;
    n = 0;
    cmd(1'b1, 1'b0, 1'b1, 13'h0005, 8'h3C);
    @(negedge clock);
    `CHK(busy, 1'b1)
    // Status reads must end the wait before the host's own limit
    do begin @(negedge clock); n++; end while (busy !== 1'b0 && n < 3000);
    `CHK(n < 400, 1'b1)
    idle();
    rd(13'h0005, 8'h3C);
  endtask : t_byte
  // Three bytes closed by window expiry; the neighbour stays untouched
  task automatic t_page;
    for (int i = 0; i < 3; i++)
      cmd(1'b1, 1'b0, 1'b0, 13'h0100 + 13'(i), 8'h50 + 8'(i));
    idle();
    for (int i = 0; i < 4; i++)
      rd(13'h0100 + 13'(i), i < 3 ? 8'h50 + 8'(i) : pat(13'h0103));
  endtask : t_page
  // A byte of another page must wait for the open page to program
  task automatic t_perr;
    perr = 1'b0;
    cmd(1'b1, 1'b0, 1'b0, 13'h0200, 8'h11);
    cmd(1'b1, 1'b0, 1'b0, 13'h0300, 8'h22);
    `CHK(perr, 1'b1)
    idle();
    rd(13'h0200, 8'h11);
    rd(13'h0300, 8'h22);
  endtask : t_perr
  task automatic t_erase;
    cmd(1'b0, 1'b1, 1'b0, 13'h0000, 8'h00);
    idle();
    rd(13'h0005, 8'hFF);
  endtask : t_erase
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 40000);
    err_count++;
    summarize();
  end
  initial begin
    {reset_n, cmd_valid, cmd_write, cmd_erase, cmd_last} = 5'b00000;
    cmd_addr  = 13'h0000;
    cmd_wdata = 8'h00;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    `CHK({chip_sel_n, wr_strobe_n, data_oe_n, rd_valid}, 4'hE)
    rd(13'h1234, pat(13'h1234));
    t_byte();
    t_page();
    t_perr();
    t_erase();
    summarize();
  end
endmodule : pee_host_test
`default_nettype wire
